// *** design/e3_performance_monitor_regs.sv ***
// error insertion masks and cleared_by_read performance counters
// assumes a synchronous 8-bit host bus and one-cycle receive events on clk
`timescale 1ns/1ps

`include "e3_performance_monitor_consts.svh"

// Notes on behaviour
// - xor upper alignment bits with upper mask
// - xor lower alignment bits with lower mask
// - xor computed parity nibble with parity mask
// - parity mask ignored while insertion is off
// - 16-bit line code violation count, high first
// - 16-bit framing error count, two bytes
// - 16-bit parity error count, two bytes
// - counter bytes read-only, clear on read
// - first byte read clears counter, holds other
module e3_performance_monitor_regs (
   input wire logic clk,
   input wire logic nrst,
   input wire e3_performance_monitor_pkg::host_req_type host_req,
   input wire logic parity_nibble_insert_on,
   input wire e3_performance_monitor_pkg::tx_overhead_type tx_in,
   input wire e3_performance_monitor_pkg::rx_event_type rx_events,
   output logic [7:0] rdata,
   output e3_performance_monitor_pkg::tx_overhead_type tx_out
);

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic rst_meta_reg;
   logic rst_n;

   // two flops release reset synchronously
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // ----------------------------------------
   // mask registers
   // ----------------------------------------
   logic [`ALIGN_MASK_W-1:0] align_upper_xor_pattern_reg;
   logic [`ALIGN_MASK_W-1:0] align_lower_xor_pattern_reg;
   logic [`PARITY_MASK_W-1:0] parity_nibble_xor_pattern_reg;

   // write strobes
   wire logic wr_upper = host_req.wr && (host_req.addr == `OFS_ALIGN_UPPER_MASK);
   wire logic wr_lower = host_req.wr && (host_req.addr == `OFS_ALIGN_LOWER_MASK);
   wire logic wr_parity = host_req.wr && (host_req.addr == `OFS_PARITY_MASK);

   // mask storage, reserved bits not kept
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         align_upper_xor_pattern_reg <= `ALIGN_MASK_W'(`MASK_RESET);
         align_lower_xor_pattern_reg <= `ALIGN_MASK_W'(`MASK_RESET);
         parity_nibble_xor_pattern_reg <= `PARITY_MASK_W'(`MASK_RESET);
      end else begin
         if (wr_upper) begin
            align_upper_xor_pattern_reg <= host_req.wdata[`ALIGN_MASK_W-1:0];
         end
         if (wr_lower) begin
            align_lower_xor_pattern_reg <= host_req.wdata[`ALIGN_MASK_W-1:0];
         end
         if (wr_parity) begin
            parity_nibble_xor_pattern_reg <= host_req.wdata[`PARITY_MASK_W-1:0];
         end
      end
   end

   // ----------------------------------------
   // transmit error insertion
   // ----------------------------------------
   e3_performance_monitor_pkg::tx_overhead_type tx_next;
   wire logic [`PARITY_MASK_W-1:0] parity_mask_used =
      parity_nibble_insert_on ? parity_nibble_xor_pattern_reg : `PARITY_MASK_W'(`MASK_RESET);

   // xor masks onto the outbound overhead
   assign tx_next.align_upper = tx_in.align_upper ^ align_upper_xor_pattern_reg;
   assign tx_next.align_lower = tx_in.align_lower ^ align_lower_xor_pattern_reg;
   assign tx_next.parity_nibble = tx_in.parity_nibble ^ parity_mask_used;

   // registered overhead out
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_out <= '0;
      end else begin
         tx_out <= tx_next;
      end
   end

   // ----------------------------------------
   // performance counters
   // ----------------------------------------
   // index 0 line code, 1 framing, 2 parity; address pair = base + 2*index
   function automatic logic hits_counter(input logic [7:0] addr, input int idx);
      logic [7:0] base;
      base = 8'(`OFS_LINE_CODE_HIGH + 2 * idx);
      return (addr[7:1] == base[7:1]);
   endfunction

   wire logic [`COUNTER_NUM-1:0] events = {rx_events.parity_error, rx_events.framing_error,
                                           rx_events.line_code_violation};
   logic [15:0] counts [`COUNTER_NUM];
   logic [`COUNTER_NUM-1:0] clears;

   genvar g;
   generate
      for (g = 0; g < `COUNTER_NUM; g++) begin : g_count
         // first byte read of the pair clears the whole count
         assign clears[g] = host_req.rd && hits_counter(host_req.addr, g);
         saturating_counter #(.WIDTH(16)) u_count (
            .clk(clk),
            .rst_n(rst_n),
            .event_pulse(events[g]),
            .clear(clears[g]),
            .count(counts[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // read decode
   // ----------------------------------------
   logic [7:0] holding_reg;
   wire logic [1:0] sel = (host_req.addr[7:1] == (`OFS_LINE_CODE_HIGH >> 1)) ? 2'd0 :
                          (host_req.addr[7:1] == (`OFS_FRAMING_HIGH >> 1)) ? 2'd1 : 2'd2;
   wire logic counter_hit = |clears;
   wire logic [15:0] sel_count = counts[sel];
   wire logic low_byte = host_req.addr[0];
   // byte read now, and the other byte kept for the second access
   wire logic [7:0] count_byte = low_byte ? sel_count[7:0] : sel_count[15:8];
   wire logic [7:0] other_byte = low_byte ? sel_count[15:8] : sel_count[7:0];
   wire logic hold_hit = host_req.rd && (host_req.addr == `OFS_HOLDING);
   wire logic [7:0] rdata_next =
      counter_hit ? count_byte :
      hold_hit ? holding_reg :
      (host_req.addr == `OFS_ALIGN_UPPER_MASK) ? 8'({align_upper_xor_pattern_reg}) :
      (host_req.addr == `OFS_ALIGN_LOWER_MASK) ? 8'({align_lower_xor_pattern_reg}) :
      (host_req.addr == `OFS_PARITY_MASK) ? 8'({parity_nibble_xor_pattern_reg}) : 8'h00;

   // read data and holding byte; holding clears on its own read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 8'h00;
         holding_reg <= 8'h00;
      end else begin
         if (host_req.rd) begin
            rdata <= rdata_next;
         end
         if (counter_hit) begin
            holding_reg <= other_byte;
         end else if (hold_hit) begin
            holding_reg <= 8'h00;
         end
      end
   end

endmodule

// *** include/e3_performance_monitor_consts.svh ***
// constants for the e3 error insertion and performance counter block
// assumes inclusion by bare name from design and bench files
`ifndef E3_PERFORMANCE_MONITOR_CONSTS_SVH
`define E3_PERFORMANCE_MONITOR_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_ALIGN_UPPER_MASK 8'h48
`define OFS_ALIGN_LOWER_MASK 8'h49
`define OFS_PARITY_MASK      8'h4a
`define OFS_LINE_CODE_HIGH 8'h50
`define OFS_LINE_CODE_LOW 8'h51
`define OFS_FRAMING_HIGH     8'h52
`define OFS_FRAMING_LOW      8'h53
`define OFS_PARITY_HIGH      8'h54
`define OFS_PARITY_LOW       8'h55
`define OFS_HOLDING          8'h6c

// ----------------------------------------
// field widths, reset values
// ----------------------------------------
`define ALIGN_MASK_W   5
`define PARITY_MASK_W  4
`define MASK_RESET     8'h00
`define COUNT_RESET    16'h0000
`define COUNT_MAX      16'hffff
`define COUNTER_NUM    3

`endif

// *** include/e3_performance_monitor_pkg.sv ***
// types for the e3 error insertion and performance counter block
// assumes e3_performance_monitor_consts.svh supplies the widths
`include "e3_performance_monitor_consts.svh"

package e3_performance_monitor_pkg;

   // ----------------------------------------
   // host bus request
   // ----------------------------------------
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } host_req_type;

   // ----------------------------------------
   // transmit overhead in and out
   // ----------------------------------------
   typedef struct packed {
      logic [`ALIGN_MASK_W-1:0] align_upper;
      logic [`ALIGN_MASK_W-1:0] align_lower;
      logic [`PARITY_MASK_W-1:0] parity_nibble;
   } tx_overhead_type;

   // ----------------------------------------
   // receive error events, one cycle each
   // ----------------------------------------
   typedef struct packed {
      logic line_code_violation;
      logic framing_error;
      logic parity_error;
   } rx_event_type;

endpackage

// *** design/saturating_counter.sv ***
// one 16-bit event counter that saturates and clears on a host read
// assumes event and clear are one-cycle pulses on clk
`timescale 1ns/1ps

`include "e3_performance_monitor_consts.svh"

module saturating_counter #(
   parameter int WIDTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic event_pulse,
   input wire logic clear,
   output logic [WIDTH-1:0] count
);

   // ----------------------------------------
   // next value
   // ----------------------------------------
   // clear drops the old total; an event in the same cycle is counted
   wire logic at_max = (count == WIDTH'(`COUNT_MAX));
   wire logic [WIDTH-1:0] base = clear ? WIDTH'(`COUNT_RESET) : count;
   wire logic [WIDTH-1:0] count_next = (event_pulse && !(at_max && !clear)) ?
      WIDTH'(base + WIDTH'(1)) : base;

   // counter register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= WIDTH'(`COUNT_RESET);
      end else begin
         count <= count_next;
      end
   end

endmodule

// *** verification/host_cpu_model.sv ***
// host processor model issuing single-strobe bus cycles
// assumes rdata is registered on the strobe edge
`timescale 1ns/1ps
module host_cpu_model (
   input wire logic clk,
   input wire logic [7:0] rdata,
   output e3_performance_monitor_pkg::host_req_type host_req
);
   initial host_req = '0;
   // one write strobe, changed just after the edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 host_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge clk);
      #1 host_req.wr = 1'b0;
   endtask
   // one read strobe, data taken a cycle after it lands
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1 host_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge clk);
      #1 host_req.rd = 1'b0;
      @(posedge clk);
      #1 d = rdata;
   endtask
endmodule

// *** verification/e3_performance_monitor_properties.sv ***
// port assertions for the mask and counter registers
// assumes one clock and bind onto e3_performance_monitor_regs
`timescale 1ns/1ps
module e3_performance_monitor_properties (
   input wire logic clk,
   input wire logic nrst,
   input wire e3_performance_monitor_pkg::host_req_type host_req,
   input wire logic parity_nibble_insert_on,
   input wire e3_performance_monitor_pkg::tx_overhead_type tx_in,
   input wire e3_performance_monitor_pkg::rx_event_type rx_events,
   input wire logic [7:0] rdata,
   input wire e3_performance_monitor_pkg::tx_overhead_type tx_out
);
   logic [1:0] up_reg;
   logic [13:0] mask_reg;
   wire up = up_reg == 2'h3;
   wire [7:0] wa = host_req.wr ? host_req.addr : 8'h00;
   wire [7:0] ra = host_req.rd ? host_req.addr : 8'h00;
   // settle count after reset, shadow of the written masks
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         up_reg <= 2'h0;
         mask_reg <= '0;
      end else begin
         if (!up) up_reg <= up_reg + 2'h1;
         if (wa == 8'h48) mask_reg[13:9] <= host_req.wdata[4:0];
         if (wa == 8'h49) mask_reg[8:4] <= host_req.wdata[4:0];
         if (wa == 8'h4a) mask_reg[3:0] <= host_req.wdata[3:0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_upper_xor: assert property (up |=>
      tx_out.align_upper == ($past(tx_in.align_upper) ^ $past(mask_reg[13:9])))
      else $error("upper alignment bits wrong");
   a_lower_xor: assert property (up |=>
      tx_out.align_lower == ($past(tx_in.align_lower) ^ $past(mask_reg[8:4])))
      else $error("lower alignment bits wrong");
   a_parity_nibble_xor: assert property (up |=> tx_out.parity_nibble == ($past(tx_in.parity_nibble) ^
      ($past(parity_nibble_insert_on) ? $past(mask_reg[3:0]) : 4'h0))) else $error("parity nibble wrong");
   a_mask_readback: assert property (up && ra == 8'h4a |=> rdata == {4'h0, mask_reg[3:0]})
      else $error("parity mask readback wrong");
   a_unmapped_zero: assert property (up && ra == 8'h4b |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_count_cleared: assert property (up && ra == 8'h50 && !rx_events.line_code_violation
      ##1 !rx_events.line_code_violation [*2] ##1 ra == 8'h51 |=> rdata == 8'h00) else $error("count not cleared");
   // no read between the two holding reads, so nothing can reload it
   a_hold_cleared: assert property (up && ra == 8'h6c ##1 !host_req.rd [*2] ##1 ra == 8'h6c |=> rdata == 8'h00)
      else $error("holding byte not cleared");
   a_rdata_stands: assert property (up && !host_req.rd |=> $stable(rdata))
      else $error("read data moved without read");
   cover property (up && ra == 8'h50);
   cover property (rx_events.parity_error [*8]);
   cover property (up && wa == 8'h4a);
endmodule
bind e3_performance_monitor_regs e3_performance_monitor_properties e3_performance_monitor_properties_inst (.clk(clk), .nrst(nrst), .host_req(host_req),
   .parity_nibble_insert_on(parity_nibble_insert_on), .tx_in(tx_in), .rx_events(rx_events), .rdata(rdata), .tx_out(tx_out));

// *** verification/e3_performance_monitor_regs_bench.sv ***
// self-checking bench for the mask and counter registers
// assumes host_cpu_model for all bus cycles
`timescale 1ns/1ps
module e3_performance_monitor_regs_bench;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic insert_on = 1'b0;
   e3_performance_monitor_pkg::tx_overhead_type tx_in = '0;
   e3_performance_monitor_pkg::rx_event_type rx_events = '0;
   e3_performance_monitor_pkg::host_req_type host_req;
   e3_performance_monitor_pkg::tx_overhead_type tx_out;
   logic [7:0] rdata;
   logic [7:0] v;
   logic [7:0] addrs [10] = '{8'h48, 8'h49, 8'h4a, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h6c, 8'h4b};
   int n_mismatch = 0;
   int checked = 0;
   int cycles = 0;
   initial forever #25 clk = ~clk;
   e3_performance_monitor_regs e3_performance_monitor_regs_inst (.clk(clk), .nrst(nrst), .host_req(host_req), .parity_nibble_insert_on(insert_on),
      .tx_in(tx_in), .rx_events(rx_events), .rdata(rdata), .tx_out(tx_out));
   host_cpu_model host_cpu_model_inst (.clk(clk), .rdata(rdata), .host_req(host_req));
   // compare and count
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      host_cpu_model_inst.rd(a, v);
      chk($sformatf("reg %h", a), {8'h00, v}, {8'h00, exp});
   endtask
   // hold an event line for n edges
   task automatic pulse(input logic [2:0] ev, input int n);
      @(posedge clk);
      #1 rx_events = ev;
      repeat (n) @(posedge clk);
      #1 rx_events = '0;
   endtask
   task automatic conclude();
      if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         n_mismatch++;
         conclude();
      end
   end
   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      #1 nrst = 1'b1;
      repeat (4) @(posedge clk);
      foreach (addrs[i]) rchk(addrs[i], 8'h00);
      host_cpu_model_inst.wr(8'h48, 8'hff);
      host_cpu_model_inst.wr(8'h49, 8'hea);
      host_cpu_model_inst.wr(8'h4a, 8'hf6);
      rchk(8'h48, 8'h1f);
      rchk(8'h49, 8'h0a);
      rchk(8'h4a, 8'h06);
      for (int on = 0; on < 2; on++) begin
         @(posedge clk);
         #1 insert_on = on[0];
         tx_in = 14'h2d5b;
         repeat (2) @(posedge clk);
         #1 chk("tx_out", {2'h0, tx_out},
            {2'h0, tx_in ^ {10'h3ea, on[0] ? 4'h6 : 4'h0}});
      end
      pulse(3'h4, 291);
      rchk(8'h50, 8'h01);
      rchk(8'h6c, 8'h23);
      rchk(8'h51, 8'h00);
      pulse(3'h2, 7);
      rchk(8'h53, 8'h07);
      rchk(8'h6c, 8'h00);
      host_cpu_model_inst.wr(8'h54, 8'hff);
      pulse(3'h1, 3);
      rchk(8'h54, 8'h00);
      rchk(8'h6c, 8'h03);
      pulse(3'h7, 65540);
      rchk(8'h55, 8'hff);
      rchk(8'h6c, 8'hff);
      rchk(8'h6c, 8'h00);
      rchk(8'h50, 8'hff);
      rchk(8'h51, 8'h00);
      conclude();
   end
endmodule
